// ==== design/cbg_glue.sv ====
// Module: processor board selects, panel buffer, interrupts, status byte
//
// Overview of operation
// RULE_01 - ROM high bank select for C000-FFFF
// RULE_02 - Three 8K ROM selects, A000/8000/6000 blocks
// RULE_03 - RAM bank spans both nibble parts together
// RULE_04 - RAM bank 0 select for 0000-03FF
// RULE_05 - RAM bank 1 select for 0400-07FF
// RULE_06 - Write line low writes, high reads RAM
// RULE_07 - Panel buffer enabled by panel select, 1800-1FFF
// RULE_08 - Panel buffer direction follows write line
// RULE_09 - Panel address and control always driven
// RULE_10 - Any low request asserts maskable interrupt
// RULE_11 - Panel request also covers retrace request
// RULE_12 - Maskable enable low forces interrupt inactive
// RULE_13 - Non-maskable request passes to processor
// RULE_14 - Non-maskable enable low forces it inactive
// RULE_15 - Reserved non-maskable request never driven low
// RULE_16 - Status byte is eight inverted inputs
// RULE_17 - Status byte driven only at 1000-17FF
// RULE_18 - Software infers panel request when none listed
// RULE_19 - Software polls supply bits for errors
// RULE_20 - Test bit sends software to panel test
// RULE_21 - Marker flag low means marker test passed
// RULE_22 - Plug-in flag low requests idle service
// RULE_23 - RAM selects qualified by strobe and power
// RULE_24 - All selects need address strobe and valid
// RULE_25 - Status bits placed at fixed positions
module cbg_glue (
   // Clock and reset
   input  wire logic               clk_sys_in,
   input  wire logic               rstn_in,
   input  wire logic               clk_en_in,
   // Processor bus
   input  wire cbg_pkg::cbg_cpu_bus_t cpu_bus_in,
   input  wire logic               power_good_in,
   output logic [7:0]              cpu_data_out,
   output logic                    cpu_data_oe_out,
   input  wire logic [7:0]         cpu_data_in,
   // Decoded selects
   output cbg_pkg::cbg_sel_t       sel_out,
   output logic                    ram_write_n_out,
   // Front-panel bus
   output logic [7:0]              panel_data_out,
   output logic                    panel_data_oe_out,
   input  wire logic [7:0]         panel_data_in,
   output logic [4:0]              panel_addr_out,
   output logic                    panel_read_n_out,
   output logic                    panel_strobe_n_out,
   output logic                    panel_enable_out,
   // Interrupts and status inputs
   input  wire cbg_pkg::cbg_req_t  req_in,
   input  wire logic               maskable_int_enable_in,
   input  wire logic               nonmaskable_int_enable_in,
   output logic                    cpu_int_req_n_out,
   output logic                    cpu_nm_int_req_n_out
);
   import cbg_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      cbg_sel_t   sel;
      logic       ram_write_n;
      logic [7:0] cpu_data;
      logic       cpu_data_oe;
      logic [7:0] panel_data;
      logic       panel_data_oe;
      logic [4:0] panel_addr;
      logic       panel_read_n;
      logic       panel_strobe_n;
      logic       panel_enable;
      logic       int_req_n;
      logic       nm_int_req_n;
   } cbg_state_t;

   cbg_state_t state_q;
   cbg_state_t state_d;
   logic       cycle_ok;
   logic [7:0] status_byte;

   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   // ************************************************************
   // Status byte
   // ************************************************************
   always_comb begin
      status_byte                 = CBG_BYTE_ZERO;                 // see RULE_25
      status_byte[CBG_SB_RETRACE] = ~req_in.retrace_int_req_n;     // see RULE_16
      status_byte[CBG_SB_PLUGIN]  = ~req_in.plugin_int_req_n;
      status_byte[CBG_SB_REMOTE]  = ~req_in.remote_if_int_req_n;
      status_byte[CBG_SB_PIFLAG]  = ~req_in.plugin_service_flag_n;
      status_byte[CBG_SB_MARKER]  = ~req_in.marker_pass_flag_n;
      status_byte[CBG_SB_SUPPLY]  = ~req_in.supply_fail_n;
      status_byte[CBG_SB_AIRFLOW] = ~req_in.airflow_fail_n;
      status_byte[CBG_SB_TEST]    = ~req_in.test_n;
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      state_d  = state_q;
      cycle_ok = cpu_bus_in.addr_valid_strobe
               & cpu_bus_in.valid_mem_addr;                        // see RULE_24
      state_d.sel = cbg_sel_t'(CBG_SEL_IDLE);
      if (cycle_ok) begin
         state_d.sel.rom_high_bank_sel_n =
            !in_range(cpu_bus_in.addr, CBG_ROMH_LO, CBG_ROMH_HI);  // see RULE_01
         state_d.sel.rom_bank_a_sel_n =
            !in_range(cpu_bus_in.addr, CBG_ROMA_LO, CBG_ROMA_HI);  // see RULE_02
         state_d.sel.rom_bank_b_sel_n =
            !in_range(cpu_bus_in.addr, CBG_ROMB_LO, CBG_ROMB_HI);  // see RULE_02
         state_d.sel.rom_bank_c_sel_n =
            !in_range(cpu_bus_in.addr, CBG_ROMC_LO, CBG_ROMC_HI);  // see RULE_02
         // One select drives both nibble parts of a bank
         state_d.sel.ram_bank0_sel_n =                             // see RULE_03
            !(in_range(cpu_bus_in.addr, CBG_RAM0_LO, CBG_RAM0_HI)  // see RULE_04
              && cpu_bus_in.io_strobe && power_good_in);           // see RULE_23
         state_d.sel.ram_bank1_sel_n =
            !(in_range(cpu_bus_in.addr, CBG_RAM1_LO, CBG_RAM1_HI)  // see RULE_05
              && cpu_bus_in.io_strobe && power_good_in);           // see RULE_23
         state_d.sel.panel_sel_n =
            !in_range(cpu_bus_in.addr, CBG_PANEL_LO, CBG_PANEL_HI);// see RULE_07
         state_d.sel.status_sel_n =
            !in_range(cpu_bus_in.addr, CBG_STATUS_LO, CBG_STATUS_HI);
      end
      state_d.ram_write_n = cpu_bus_in.write_n;                    // see RULE_06

      // Panel data buffer, enable and direction
      state_d.panel_data_oe = !state_d.sel.panel_sel_n
                            && !cpu_bus_in.write_n;                // see RULE_08
      state_d.panel_data    = cpu_data_in;
      // Address and control lines always driven
      state_d.panel_addr     = cpu_bus_in.addr[4:0];               // see RULE_09
      state_d.panel_enable   = !state_d.sel.panel_sel_n;
      state_d.panel_read_n   = !(!state_d.sel.panel_sel_n
                                 && cpu_bus_in.write_n);
      state_d.panel_strobe_n = !(!state_d.sel.panel_sel_n
                                 && cpu_bus_in.io_strobe);

      // Processor data bus: status byte or panel read data
      state_d.cpu_data_oe = cpu_bus_in.write_n
                          && (!state_d.sel.status_sel_n            // see RULE_17
                              || !state_d.sel.panel_sel_n);        // see RULE_08
      state_d.cpu_data    = !state_d.sel.status_sel_n
                          ? status_byte : panel_data_in;

      // Interrupt merge; panel request already carries retrace
      state_d.int_req_n = !(maskable_int_enable_in                 // see RULE_12
                            && (!req_in.plugin_int_req_n           // see RULE_10
                                || !req_in.remote_if_int_req_n
                                || !req_in.panel_int_req_n));      // see RULE_11
      state_d.nm_int_req_n = !(nonmaskable_int_enable_in           // see RULE_14
                               && !req_in.plugin_nm_req_n);        // see RULE_13
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q                <= '0;
         state_q.sel            <= cbg_sel_t'(CBG_SEL_IDLE);
         state_q.ram_write_n    <= 1'b1;
         state_q.panel_read_n   <= 1'b1;
         state_q.panel_strobe_n <= 1'b1;
         state_q.int_req_n      <= 1'b1;
         state_q.nm_int_req_n   <= 1'b1;
         state_q.cpu_data       <= CBG_BYTE_ZERO;
         state_q.panel_addr     <= CBG_ADDR_ZERO;
      end else if (clk_en_in) begin
         state_q <= state_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign sel_out              = state_q.sel;
   assign ram_write_n_out      = state_q.ram_write_n;
   assign cpu_data_out         = state_q.cpu_data;
   assign cpu_data_oe_out      = state_q.cpu_data_oe;
   assign panel_data_out       = state_q.panel_data;
   assign panel_data_oe_out    = state_q.panel_data_oe;
   assign panel_addr_out       = state_q.panel_addr;
   assign panel_read_n_out     = state_q.panel_read_n;
   assign panel_strobe_n_out   = state_q.panel_strobe_n;
   assign panel_enable_out     = state_q.panel_enable;
   assign cpu_int_req_n_out    = state_q.int_req_n;
   assign cpu_nm_int_req_n_out = state_q.nm_int_req_n;

endmodule : cbg_glue

// ==== design/cbg_pkg.sv ====
// Package: constants and carriers for the processor board glue block
package cbg_pkg;

   // ************************************************************
   // Address map
   // ************************************************************
   localparam logic [15:0] CBG_RAM0_LO       = 16'h0000;
   localparam logic [15:0] CBG_RAM0_HI       = 16'h03FF;
   localparam logic [15:0] CBG_RAM1_LO       = 16'h0400;
   localparam logic [15:0] CBG_RAM1_HI       = 16'h07FF;
   localparam logic [15:0] CBG_STATUS_LO     = 16'h1000;
   localparam logic [15:0] CBG_STATUS_HI     = 16'h17FF;
   localparam logic [15:0] CBG_PANEL_LO      = 16'h1800;
   localparam logic [15:0] CBG_PANEL_HI      = 16'h1FFF;
   localparam logic [15:0] CBG_ROMC_LO       = 16'h6000;
   localparam logic [15:0] CBG_ROMC_HI       = 16'h7FFF;
   localparam logic [15:0] CBG_ROMB_LO       = 16'h8000;
   localparam logic [15:0] CBG_ROMB_HI       = 16'h9FFF;
   localparam logic [15:0] CBG_ROMA_LO       = 16'hA000;
   localparam logic [15:0] CBG_ROMA_HI       = 16'hBFFF;
   localparam logic [15:0] CBG_ROMH_LO       = 16'hC000;
   localparam logic [15:0] CBG_ROMH_HI       = 16'hFFFF;
   localparam logic [15:0] CBG_STATUS_OFS    = 16'h1000;

   // ************************************************************
   // Status byte bit positions
   // ************************************************************
   localparam int CBG_SB_RETRACE = 0;
   localparam int CBG_SB_PLUGIN  = 1;
   localparam int CBG_SB_REMOTE  = 2;
   localparam int CBG_SB_PIFLAG  = 3;
   localparam int CBG_SB_MARKER  = 4;
   localparam int CBG_SB_SUPPLY  = 5;
   localparam int CBG_SB_AIRFLOW = 6;
   localparam int CBG_SB_TEST    = 7;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] CBG_SEL_IDLE  = 8'hFF;
   localparam logic [7:0] CBG_BYTE_ZERO = 8'h00;
   localparam logic [4:0] CBG_ADDR_ZERO = 5'h00;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [15:0] addr;
      logic        write_n;
      logic        valid_mem_addr;
      logic        addr_valid_strobe;
      logic        io_strobe;
   } cbg_cpu_bus_t;

   typedef struct packed {
      logic retrace_int_req_n;
      logic plugin_int_req_n;
      logic remote_if_int_req_n;
      logic panel_int_req_n;
      logic plugin_nm_req_n;
      logic plugin_service_flag_n;
      logic marker_pass_flag_n;
      logic supply_fail_n;
      logic airflow_fail_n;
      logic test_n;
   } cbg_req_t;

   typedef struct packed {
      logic rom_high_bank_sel_n;
      logic rom_bank_a_sel_n;
      logic rom_bank_b_sel_n;
      logic rom_bank_c_sel_n;
      logic ram_bank0_sel_n;
      logic ram_bank1_sel_n;
      logic panel_sel_n;
      logic status_sel_n;
   } cbg_sel_t;

endpackage : cbg_pkg

// ==== verif/cbg_glue_chk.sv ====
// Checker: concurrent assertions on the glue block ports
module cbg_glue_chk (
   // Clock, reset and inputs
   input wire logic                  clk_sys_in,
   input wire logic                  rstn_in,
   input wire logic                  clk_en_in,
   input wire cbg_pkg::cbg_cpu_bus_t cpu_bus_in,
   input wire logic                  power_good_in,
   input wire cbg_pkg::cbg_req_t     req_in,
   input wire logic                  maskable_int_enable_in,
   input wire logic                  nonmaskable_int_enable_in,
   // Outputs watched
   input wire logic [7:0]            cpu_data_out,
   input wire logic                  cpu_data_oe_out,
   input wire cbg_pkg::cbg_sel_t     sel_out,
   input wire logic                  ram_write_n_out,
   input wire logic                  panel_data_oe_out,
   input wire logic                  panel_enable_out,
   input wire logic                  cpu_int_req_n_out,
   input wire logic                  cpu_nm_int_req_n_out
);
   import cbg_pkg::*;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   logic [15:0] a;
   logic        va, ram;
   logic [7:0]  sb;
   assign a   = cpu_bus_in.addr;
   assign va  = cpu_bus_in.addr_valid_strobe & cpu_bus_in.valid_mem_addr;
   assign ram = va & cpu_bus_in.io_strobe & power_good_in;
   assign sb  = {req_in.test_n, req_in.airflow_fail_n, req_in.supply_fail_n,
                 req_in.marker_pass_flag_n, req_in.plugin_service_flag_n,
                 req_in.remote_if_int_req_n, req_in.plugin_int_req_n,
                 req_in.retrace_int_req_n};
   // Status read request and its answer
   sequence s_stat_rd;
      clk_en_in && va && a[15:11] == 5'h02 && cpu_bus_in.write_n;
   endsequence
   sequence s_stat_ans;
      cpu_data_oe_out && !sel_out.status_sel_n && cpu_data_out == ~$past(sb);
   endsequence
   AST_ROM_HIGH: assert property (clk_en_in |=>
      sel_out.rom_high_bank_sel_n == $past(!(va && a[15:14] == 2'h3)))
      else $error("high rom select wrong");
   AST_ROM_8K: assert property (clk_en_in |=>
      {sel_out.rom_bank_a_sel_n, sel_out.rom_bank_b_sel_n,
       sel_out.rom_bank_c_sel_n} == $past({!(va && a[15:13] == 3'h5),
       !(va && a[15:13] == 3'h4), !(va && a[15:13] == 3'h3)}))
      else $error("8k rom select wrong");
   AST_RAM0: assert property (clk_en_in |=>
      sel_out.ram_bank0_sel_n == $past(!(ram && a[15:10] == 6'h00)))
      else $error("ram bank 0 select wrong");
   AST_RAM1: assert property (clk_en_in |=>
      sel_out.ram_bank1_sel_n == $past(!(ram && a[15:10] == 6'h01)))
      else $error("ram bank 1 select wrong");
   AST_PANEL_SEL: assert property (clk_en_in |=>
      panel_enable_out == $past(va && a[15:11] == 5'h03) &&
      panel_enable_out != sel_out.panel_sel_n)
      else $error("panel select wrong");
   AST_PANEL_DIR: assert property (
      panel_data_oe_out == (panel_enable_out && !ram_write_n_out))
      else $error("panel direction wrong");
   AST_IRQ: assert property (clk_en_in |=>
      cpu_int_req_n_out == $past(!(maskable_int_enable_in &&
      !(req_in.plugin_int_req_n && req_in.remote_if_int_req_n &&
      req_in.panel_int_req_n))))
      else $error("maskable interrupt wrong");
   AST_NMI: assert property (clk_en_in |=>
      cpu_nm_int_req_n_out ==
      $past(!(nonmaskable_int_enable_in && !req_in.plugin_nm_req_n)))
      else $error("non-maskable interrupt wrong");
   AST_STATUS: assert property (s_stat_rd |=> s_stat_ans)
      else $error("status byte wrong");
endmodule : cbg_glue_chk

bind cbg_glue cbg_glue_chk cbg_glue_chk_inst (.clk_sys_in, .rstn_in,
   .clk_en_in, .cpu_bus_in, .power_good_in, .req_in, .maskable_int_enable_in,
   .nonmaskable_int_enable_in, .cpu_data_out, .cpu_data_oe_out, .sel_out,
   .ram_write_n_out, .panel_data_oe_out, .panel_enable_out,
   .cpu_int_req_n_out, .cpu_nm_int_req_n_out);

// ==== verif/cbg_glue_tb_top.sv ====
// Testbench: random bus traffic checked against a reference model
module cbg_glue_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cbg_pkg::*;
   logic         clk_sys_in = 1'b0;
   logic         rstn_in = 1'b0;
   logic         en = 1'b1, pg = 1'b0, mie = 1'b0, nonmaskable_int_enable = 1'b0;
   cbg_cpu_bus_t bus = '0;
   cbg_req_t     req = '1;
   cbg_sel_t     sel;
   logic [7:0]   cdi = 8'h00, cdo, pdo, pdi;
   logic [4:0]   pad;
   logic         coe, rwn, poe, prdn, pstbn, pen, intn, nmin;
   logic [15:0]  r = 16'h0042;
   logic [36:0]  o, e;
   int           n_errors = 0, n_checks = 0, cyc = 0;
   always #50 clk_sys_in = ~clk_sys_in;
   cbg_glue cbg_glue_inst (.clk_sys_in, .rstn_in, .clk_en_in(en),
      .cpu_bus_in(bus), .power_good_in(pg), .cpu_data_out(cdo),
      .cpu_data_oe_out(coe), .cpu_data_in(cdi), .sel_out(sel),
      .ram_write_n_out(rwn), .panel_data_out(pdo), .panel_data_oe_out(poe),
      .panel_data_in(pdi), .panel_addr_out(pad), .panel_read_n_out(prdn),
      .panel_strobe_n_out(pstbn), .panel_enable_out(pen), .req_in(req),
      .maskable_int_enable_in(mie), .nonmaskable_int_enable_in(nonmaskable_int_enable),
      .cpu_int_req_n_out(intn), .cpu_nm_int_req_n_out(nmin));
   cbg_panel_model cbg_panel_model_inst (.clk_sys_in, .addr_in(pad),
      .read_n_in(prdn), .data_out(pdi));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      for (int i = 0; i < 16; i++) s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
      return s;
   endfunction : lfsr
   // Reference: outputs expected one edge after these inputs
   function automatic logic [36:0] model();
      logic [15:0] a;
      logic        va, ps, rd, dr;
      logic [7:0]  s, sb;
      a = bus.addr;
      va = bus.addr_valid_strobe & bus.valid_mem_addr;
      rd = bus.write_n;
      s[7] = !(va && a >= 16'hC000);
      s[6] = !(va && a >= 16'hA000 && a < 16'hC000);
      s[5] = !(va && a >= 16'h8000 && a < 16'hA000);
      s[4] = !(va && a >= 16'h6000 && a < 16'h8000);
      s[3] = !(va && bus.io_strobe && pg && a < 16'h0400);
      s[2] = !(va && bus.io_strobe && pg && a >= 16'h0400 && a < 16'h0800);
      s[1] = !(va && a >= 16'h1800 && a < 16'h2000);
      s[0] = !(va && a >= 16'h1000 && a < 16'h1800);
      ps = !s[1];
      dr = (!s[0] || ps) && rd;
      sb = ~{req.test_n, req.airflow_fail_n, req.supply_fail_n,
             req.marker_pass_flag_n, req.plugin_service_flag_n,
             req.remote_if_int_req_n, req.plugin_int_req_n,
             req.retrace_int_req_n};
      return {s, !(mie && !(req.plugin_int_req_n && req.remote_if_int_req_n
              && req.panel_int_req_n)), !(nonmaskable_int_enable && !req.plugin_nm_req_n), rd,
              a[4:0], !(ps && rd), !(ps && bus.io_strobe), ps, ps && !rd, dr,
              dr ? (ps ? pdi : sb) : 8'h00, (ps && !rd) ? cdi : 8'h00};
   endfunction : model
   task automatic check(input logic [36:0] seen, input logic [36:0] want);
      n_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic part(input int h, input int l);
      logic [36:0] m;
      m = (37'h1 << (h - l + 1)) - 37'h1;
      check((o >> l) & m, (e >> l) & m);
   endtask : part
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      e = {8'hFF, 3'h7, 5'h00, 2'h3, 3'h0, 16'h0000};
      repeat (20) @(posedge clk_sys_in);
      #5;
      check({sel, intn, nmin, rwn, pad, prdn, pstbn, pen, poe, coe, cdo, pdo},
            e);
      rstn_in = 1'b1;
      repeat (3000) begin
         r = lfsr(r);
         bus.addr = r;
         r = lfsr(r);
         if (r[15]) bus.addr[15:13] = 3'h0;
         {bus.valid_mem_addr, bus.addr_valid_strobe} = {|r[1:0], |r[3:2]};
         {bus.io_strobe, bus.write_n, pg} = {r[4], r[5], |r[7:6]};
         {mie, nonmaskable_int_enable, en} = {|r[9:8], r[10], |r[13:11]};
         r = lfsr(r);
         cdi = r[7:0];
         req = r[15:6];
         // Panel request pulled low whenever the retrace request is low
         req.panel_int_req_n &= req.retrace_int_req_n;
         if (en) e = model();
         @(posedge clk_sys_in);
         #5;
         o = {sel, intn, nmin, rwn, pad, prdn, pstbn, pen, poe, coe,
              coe ? cdo : 8'h00, poe ? pdo : 8'h00};
         part(36, 33);
         part(32, 31);
         part(30, 29);
         part(28, 27);
         part(26, 18);
         part(17, 0);
      end
      complete_run();
   end
endmodule : cbg_glue_tb_top

// ==== verif/cbg_panel_model.sv ====
// Partner model: front-panel logic answering panel bus reads
module cbg_panel_model (
   // Clock
   input  wire logic       clk_sys_in,
   // Panel bus
   input  wire logic [4:0] addr_in,
   input  wire logic       read_n_in,
   output logic [7:0]      data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last_q = 8'h00;
   always_ff @(posedge clk_sys_in) last_q <= data_out;
   // Answer a read, otherwise a toggling pattern
   always_comb data_out = !read_n_in ? {3'h5, addr_in} : ~last_q;
endmodule : cbg_panel_model
